/* File: fsc_ctrl.sv */
// Host controller that drives a flash status-register device over its pins.
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - Bits 6..0 are ignored until the device reports ready.
// - Reserved bit 0 is masked out whenever status is evaluated.
// - Bits 5 and 4 both set mean an improper command sequence.
// - Supply flag is not trusted unless supply is at its high level.
// - Lock state is learned by read-identifier then reading the codes.
module fsc_ctrl #(
   parameter int ADDR_W = 19
) (
   input wire logic sys_clk, // 20 MHz clock.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic wb_cyc_i, // Wishbone cycle.
   input wire logic wb_stb_i, // Wishbone strobe.
   input wire logic wb_we_i, // Wishbone write enable.
   input wire logic [7:0] wb_adr_i, // Wishbone byte address.
   input wire logic [31:0] wb_dat_i, // Wishbone write data.
   input wire logic [3:0] wb_sel_i, // Wishbone byte lanes.
   output logic [31:0] wb_dat_o, // Wishbone read data.
   output logic wb_ack_o, // Wishbone acknowledge.
   output logic irq, // Level interrupt.
   output fsc_pkg::fsc_pins_t flash_o, // Flash pin outputs.
   input wire logic [7:0] dq_i, // Flash data pins, input side.
   input wire logic ready_busy_i, // Flash ready/busy pin.
   input wire logic supply_high_i // Programming supply at high level.
);

   // The device has 19 address pins; anything wider cannot be driven.
   if (ADDR_W < 1 || ADDR_W > 19) begin
      $error("ADDR_W must lie in 1..19");
   end

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [9:0] sync1_reg;
   logic [9:0] sync2_reg;
   logic [7:0] dq_sync;
   logic ready_sync;
   logic supply_sync;

   // Pins come from an unclocked device, so each passes two flops.
   always_ff @(posedge sys_clk) begin
      sync1_reg <= {supply_high_i, ready_busy_i, dq_i};
      sync2_reg <= sync1_reg;
   end
   assign dq_sync = sync2_reg[7:0];
   assign ready_sync = sync2_reg[8];
   assign supply_sync = sync2_reg[9];

   // ==========================================================
   // Wishbone slave registers
   // ==========================================================
   logic [ADDR_W-1:0] addr_reg;
   logic [7:0] wdata_reg;
   logic [7:0] rdata_reg;
   logic [7:0] status_reg;
   logic [6:0] irq_stat_reg;
   logic [6:0] irq_en_reg;
   logic [6:0] irq_ev;
   logic [31:0] lane_mask;
   logic [31:0] wr_word;
   logic wb_req;
   logic wb_wr;
   logic start;
   logic busy;
   fsc_pkg::fsc_op_t op_reg;

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr = wb_req && wb_we_i;
   assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wr_word = wb_dat_i & lane_mask;
   // A command written while busy is dropped; software polls busy first.
   assign start = wb_wr && wb_adr_i == fsc_pkg::REG_CMD && wb_sel_i[0]
                  && !busy;

   // Every access is acknowledged one cycle after it is seen.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   // Address, write data and interrupt enable, per byte lane.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         addr_reg <= '0;
         wdata_reg <= 8'h00;
         irq_en_reg <= fsc_pkg::IRQ_EN_RESET;
         op_reg <= fsc_pkg::OP_READ_ARRAY;
      end else if (wb_wr) begin
         if (wb_adr_i == fsc_pkg::REG_ADDR) begin
            addr_reg <= (addr_reg & ~lane_mask[ADDR_W-1:0])
                        | wr_word[ADDR_W-1:0];
         end
         if (wb_adr_i == fsc_pkg::REG_WDATA && wb_sel_i[0]) begin
            wdata_reg <= wb_dat_i[7:0];
         end
         if (wb_adr_i == fsc_pkg::REG_IRQ_EN && wb_sel_i[0]) begin
            irq_en_reg <= wb_dat_i[6:0];
         end
         if (start) begin
            op_reg <= fsc_pkg::fsc_op_t'(wb_dat_i[3:0]);
         end
      end
   end

   // Read mux; unmapped offsets read as zero and are still acknowledged.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wb_dat_o <= 32'h0000_0000;
      end else begin
         unique case (wb_adr_i)
            fsc_pkg::REG_ADDR: wb_dat_o <= 32'(addr_reg);
            fsc_pkg::REG_WDATA: wb_dat_o <= {24'h000000, wdata_reg};
            fsc_pkg::REG_CMD: wb_dat_o <= {28'h0000000, op_reg};
            fsc_pkg::REG_STATUS: wb_dat_o <= {21'h000000, supply_sync,
               ready_sync, busy, status_reg};
            fsc_pkg::REG_RDATA: wb_dat_o <= {24'h000000, rdata_reg};
            fsc_pkg::REG_IRQ_STAT: wb_dat_o <= {25'h0000000, irq_stat_reg};
            fsc_pkg::REG_IRQ_EN: wb_dat_o <= {25'h0000000, irq_en_reg};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // Sticky events; a new event beats a clear in the same cycle.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_stat_reg <= 7'h00;
      end else if (wb_wr && wb_adr_i == fsc_pkg::REG_IRQ_CLR && wb_sel_i[0])
      begin
         irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[6:0]) | irq_ev;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_ev;
      end
   end
   assign irq = |(irq_stat_reg & irq_en_reg);

   // ==========================================================
   // Command sequencer
   // ==========================================================
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_CMD1 = 3'b001, ST_CMD2 = 3'b011,
      ST_READ = 3'b010, ST_DONE = 3'b110
   } fsc_state_t;

   fsc_state_t state_reg;
   logic [7:0] cnt_reg;
   fsc_pkg::fsc_seq_t seq_reg;
   fsc_pkg::fsc_seq_t seq_next;
   logic wr_end;
   logic rd_end;

   // Each operation maps to one or two write cycles and, except clear status, a follow-up.
   always_comb begin
      seq_next = '{fsc_pkg::CMD_READ_ARRAY, 8'h00, 1'b0, fsc_pkg::ACT_READ};
      unique case (fsc_pkg::fsc_op_t'(wb_dat_i[3:0]))
         fsc_pkg::OP_BYTE_WRITE: seq_next = '{fsc_pkg::CMD_WRITE_SETUP,
            wdata_reg, 1'b1, fsc_pkg::ACT_POLL};
         fsc_pkg::OP_ERASE: seq_next = '{fsc_pkg::CMD_ERASE_SETUP,
            fsc_pkg::CMD_CONFIRM, 1'b1, fsc_pkg::ACT_POLL};
         fsc_pkg::OP_SET_BLOCK_LOCK: seq_next = '{fsc_pkg::CMD_LOCK_SETUP,
            fsc_pkg::CMD_SET_BLOCK, 1'b1, fsc_pkg::ACT_POLL};
         fsc_pkg::OP_SET_MASTER_LOCK: seq_next = '{fsc_pkg::CMD_LOCK_SETUP,
            fsc_pkg::CMD_SET_MASTER, 1'b1, fsc_pkg::ACT_POLL};
         fsc_pkg::OP_CLEAR_LOCKS: seq_next = '{fsc_pkg::CMD_LOCK_SETUP,
            fsc_pkg::CMD_CONFIRM, 1'b1, fsc_pkg::ACT_POLL};
         fsc_pkg::OP_SUSPEND: seq_next = '{fsc_pkg::CMD_SUSPEND,
            8'h00, 1'b0, fsc_pkg::ACT_POLL};
         // The device goes busy again after resume, so poll.
         fsc_pkg::OP_RESUME: seq_next = '{fsc_pkg::CMD_CONFIRM,
            8'h00, 1'b0, fsc_pkg::ACT_POLL};
         fsc_pkg::OP_CLEAR_STATUS: seq_next = '{fsc_pkg::CMD_CLEAR_STATUS,
            8'h00, 1'b0, fsc_pkg::ACT_NONE};
         fsc_pkg::OP_READ_STATUS: seq_next = '{fsc_pkg::CMD_READ_STATUS,
            8'h00, 1'b0, fsc_pkg::ACT_POLL};
         fsc_pkg::OP_READ_ID: seq_next = '{fsc_pkg::CMD_READ_ID,
            8'h00, 1'b0, fsc_pkg::ACT_READ};
         default: ;
      endcase
   end

   assign wr_end = cnt_reg == 8'(fsc_pkg::WR_LAST);
   assign rd_end = cnt_reg == 8'(fsc_pkg::RD_SAMPLE);
   assign busy = state_reg != ST_IDLE;

   // Sequencer: write cycles, then a poll or a single read (none for clear status), with no status command needed.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 8'h00;
         seq_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
         unique case (state_reg)
            ST_IDLE: begin
               cnt_reg <= 8'h00;
               if (start) begin
                  seq_reg <= seq_next;
                  state_reg <= ST_CMD1;
               end
            end
            ST_CMD1, ST_CMD2: begin
               if (wr_end) begin
                  cnt_reg <= 8'h00;
                  if (state_reg == ST_CMD1 && seq_reg.two) begin
                     state_reg <= ST_CMD2;
                  end else if (seq_reg.act == fsc_pkg::ACT_NONE) begin
                     state_reg <= ST_DONE;
                  end else begin
                     state_reg <= ST_READ;
                  end
               end
            end
            ST_READ: begin
               if (rd_end) begin
                  cnt_reg <= 8'h00;
                  // Busy: bits 6..0 are meaningless, read again.
                  if (seq_reg.act != fsc_pkg::ACT_POLL
                      || dq_sync[fsc_pkg::SR_READY]) begin
                     state_reg <= ST_DONE;
                  end
               end
            end
            ST_DONE: state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Capture of read data and of the masked device status.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata_reg <= 8'h00;
         status_reg <= fsc_pkg::STATUS_RESET;
      end else if (state_reg == ST_READ && rd_end) begin
         rdata_reg <= dq_sync;
         if (seq_reg.act == fsc_pkg::ACT_POLL
             && dq_sync[fsc_pkg::SR_READY]) begin
            status_reg <= dq_sync & fsc_pkg::SR_VALID_MASK;
         end
      end
   end

   // Status decode at completion. The supply and lock flags only mean
   // something after a poll that followed a command sequence.
   always_comb begin
      irq_ev = 7'h00;
      if (state_reg == ST_DONE) begin
         irq_ev[fsc_pkg::IRQ_DONE] = 1'b1;
         if (seq_reg.act == fsc_pkg::ACT_POLL) begin
            irq_ev[fsc_pkg::IRQ_ERASE_ERR] = status_reg[5];
            irq_ev[fsc_pkg::IRQ_PROG_ERR] = status_reg[4];
            irq_ev[fsc_pkg::IRQ_SEQ_ERR] =
               status_reg[5] && status_reg[4];
            // A low-supply report is unreliable off the high level.
            irq_ev[fsc_pkg::IRQ_SUPPLY] =
               status_reg[3] && supply_sync;
            irq_ev[fsc_pkg::IRQ_PROTECT] = status_reg[1];
            irq_ev[fsc_pkg::IRQ_PAUSED] =
               status_reg[6] || status_reg[2];
         end
      end
   end

   // ==========================================================
   // Pin drive, registered so the device sees clean edges
   // ==========================================================
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         flash_o <= '{19'h00000, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
      end else begin
         flash_o.addr <= 19'(addr_reg);
         flash_o.rp_n <= 1'b1;
         flash_o.ce_n <= !(state_reg inside {ST_CMD1, ST_CMD2, ST_READ});
         flash_o.dq_oe <= state_reg inside {ST_CMD1, ST_CMD2};
         flash_o.dq <= state_reg == ST_CMD2 ? seq_reg.second : seq_reg.first;
         flash_o.we_n <= !(state_reg inside {ST_CMD1, ST_CMD2}
            && cnt_reg < 8'(fsc_pkg::WE_LOW_CYC));
         // Output enable drops one cycle per read so each poll is fresh.
         flash_o.oe_n <= !(state_reg == ST_READ && !rd_end);
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   // Every check runs on the one system clock and sleeps during reset.
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   reserved_masked_a: assert property (
      status_reg[0] == 1'b0) else $error("reserved status bit kept");

   busy_ignored_a: assert property (
      state_reg == ST_READ && rd_end && !dq_sync[7]
      && seq_reg.act == fsc_pkg::ACT_POLL
      |=> $stable(status_reg) && state_reg == ST_READ)
      else $error("busy status was taken");

   ready_taken_a: assert property (
      state_reg == ST_READ && rd_end && dq_sync[7]
      && seq_reg.act == fsc_pkg::ACT_POLL
      |=> status_reg == ($past(dq_sync) & 8'hFE) && state_reg == ST_DONE)
      else $error("ready status not captured");

   seq_error_a: assert property (
      state_reg == ST_DONE && seq_reg.act == fsc_pkg::ACT_POLL
      && status_reg[5] && status_reg[4] |=> irq_stat_reg[3])
      else $error("sequence error not flagged");

   supply_trust_a: assert property (
      irq_ev[fsc_pkg::IRQ_SUPPLY] |-> supply_sync && status_reg[3]
      && state_reg == ST_DONE) else $error("supply flag untrusted");

   only_after_seq_a: assert property (
      (irq_ev[5] || irq_ev[4] || irq_ev[1])
      |-> seq_reg.act == fsc_pkg::ACT_POLL) else $error("flag outside poll");

   clear_cmd_a: assert property (
      start && wb_dat_i[3:0] == 4'h8 |=> ##1 flash_o.dq == 8'h50
      && flash_o.dq_oe) else $error("clear status not driven");

   read_id_a: assert property (
      start && wb_dat_i[3:0] == 4'hA |=> ##1 flash_o.dq == 8'h90)
      else $error("read identifier not driven");

   pins_exclusive_a: assert property (
      !(flash_o.we_n == 1'b0 && flash_o.oe_n == 1'b0))
      else $error("we and oe both low");

   set_wins_a: assert property (
      irq_ev[0] |=> irq_stat_reg[0]) else $error("event lost to clear");

   irq_level_a: assert property (
      irq == |(irq_stat_reg & irq_en_reg)) else $error("irq level wrong");

endmodule

/* File: fsc_pkg.sv */
// Package for the flash status controller: codes, offsets, timing, types.
package fsc_pkg;

   // ==========================================================
   // Flash command codes written on the data pins
   // ==========================================================
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
   localparam logic [7:0] CMD_SET_BLOCK = 8'h01;
   localparam logic [7:0] CMD_SET_MASTER = 8'hF1;

   // ==========================================================
   // Bit positions of the device status byte
   // ==========================================================
   localparam int SR_READY = 7;
   localparam int SR_ERASE_PAUSED = 6;
   localparam int SR_ERASE_ERR = 5;
   localparam int SR_PROG_ERR = 4;
   localparam int SR_SUPPLY_LOW = 3;
   localparam int SR_PROG_PAUSED = 2;
   localparam int SR_PROTECT = 1;
   localparam logic [7:0] SR_VALID_MASK = 8'hFE;

   // ==========================================================
   // Register offsets on the Wishbone side and reset values
   // ==========================================================
   localparam logic [7:0] REG_ADDR = 8'h00;
   localparam logic [7:0] REG_WDATA = 8'h04;
   localparam logic [7:0] REG_CMD = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_RDATA = 8'h10;
   localparam logic [7:0] REG_IRQ_STAT = 8'h14;
   localparam logic [7:0] REG_IRQ_CLR = 8'h18;
   localparam logic [7:0] REG_IRQ_EN = 8'h1C;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [6:0] IRQ_EN_RESET = 7'h00;

   // ==========================================================
   // Interrupt bit positions
   // ==========================================================
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERASE_ERR = 1;
   localparam int IRQ_PROG_ERR = 2;
   localparam int IRQ_SEQ_ERR = 3;
   localparam int IRQ_SUPPLY = 4;
   localparam int IRQ_PROTECT = 5;
   localparam int IRQ_PAUSED = 6;
   localparam int IRQ_W = 7;

   // ==========================================================
   // Pin timing, in ns and in 20 MHz cycles (rounded up)
   // ==========================================================
   localparam int CLK_MHZ = 20;
   localparam int WE_LOW_NS = 100;
   localparam int WE_HIGH_NS = 100;
   localparam int ACCESS_NS = 200;
   localparam int WE_LOW_CYC = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int WE_HIGH_CYC = (WE_HIGH_NS * CLK_MHZ + 999) / 1000;
   localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int WR_LAST = WE_LOW_CYC + WE_HIGH_CYC;
   localparam int RD_SAMPLE = ACCESS_CYC + 3;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [3:0] {
      OP_READ_ARRAY, OP_BYTE_WRITE, OP_ERASE, OP_SET_BLOCK_LOCK,
      OP_SET_MASTER_LOCK, OP_CLEAR_LOCKS, OP_SUSPEND, OP_RESUME,
      OP_CLEAR_STATUS, OP_READ_STATUS, OP_READ_ID
   } fsc_op_t;

   typedef enum logic [1:0] {ACT_NONE, ACT_READ, ACT_POLL} fsc_act_t;

   typedef struct packed {
      logic [7:0] first;
      logic [7:0] second;
      logic two;
      fsc_act_t act;
   } fsc_seq_t;

   typedef struct packed {
      logic [18:0] addr;
      logic [7:0] dq;
      logic dq_oe;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic rp_n;
   } fsc_pins_t;

endpackage

/* File: fsc_flash_model.sv */
// Behavioural model of the flash device status logic seen at its pins.
`timescale 1ns/1ps
// ==========================================================
// Flash device model
// ==========================================================
module fsc_flash_model #(
   parameter logic [7:0] ID_CODE = 8'hA5 // Arbitrary identifier value.
) (
   input wire logic sys_clk, // Samples the write strobe and times the busy period.
   input wire fsc_pkg::fsc_pins_t pins, // Pins from the controller.
   input wire logic [7:0] fail_bits, // Error bits raised at completion.
   input wire logic [7:0] busy_len, // Busy length in clocks, at least 1.
   output logic [7:0] dq, // Data pins, device side.
   output logic ready_busy // High while ready.
);
   logic [7:0] stat_reg = 8'h80;
   logic [7:0] cnt = 8'h00;
   logic [7:0] setup = 8'h00;
   logic [7:0] last_op = 8'h00;
   logic [7:0] last_dq = 8'h00;
   logic we_q = 1'b1;
   logic [1:0] mode = 2'd1;

   // Commands are latched on the rising write strobe; flags change at the end of an operation,
   // on the second cycle of a two-cycle command, or on a clear, suspend or confirm write, never continuously.
   always @(posedge sys_clk) begin
      we_q <= pins.we_n;
      last_dq <= dq;
      if (cnt == 8'h01) begin
         stat_reg <= stat_reg | 8'h80
                     | fail_bits;
      end
      if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
      end
      if (!pins.ce_n && !we_q && pins.we_n) begin
         mode <= 2'd1;
         if (setup != 8'h00) begin
            last_op <= setup;
            setup <= 8'h00;
            stat_reg[7] <= 1'b0;
            cnt <= busy_len;
         end else begin
            case (pins.dq)
               8'hFF: mode <= 2'd0;
               8'h90: mode <= 2'd2;
               8'h70: mode <= 2'd1;
               8'h50: stat_reg <= stat_reg & 8'hC4;
               8'hB0: stat_reg[(last_op == 8'h20) ? 6 : 2]
                  <= 1'b1;
               8'hD0: begin
                  stat_reg <= stat_reg & 8'h3B;
                  cnt <= busy_len;
               end
               default: setup <= pins.dq;
            endcase
         end
      end
   end

   // Junk in the low bits while busy and a set reserved bit make sure the
   // controller ignores both; a released bus toggles every clock.
   always_comb begin
      if (!pins.ce_n && !pins.oe_n) begin
         if (mode == 2'd0) begin
            dq = pins.addr[7:0] ^ 8'h5A;
         end else if (mode == 2'd2) begin
            dq = ID_CODE;
         end else begin
            dq = stat_reg[7] ? (stat_reg | 8'h01)
               : 8'h7F;
         end
      end else begin
         dq = ~last_dq;
      end
   end
   assign ready_busy = stat_reg[7];
endmodule

/* File: flash_wsm_status_register_tb.sv */
// Self-checking testbench for the flash status controller.
`timescale 1ns/1ps
module flash_wsm_status_register_tb;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_dat = 32'h0;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack;
   logic irq;
   fsc_pkg::fsc_pins_t pins;
   logic [7:0] mdl_dq;
   logic [7:0] dq_bus;
   logic ready_busy;
   logic supply_hi = 1'b1;
   logic [7:0] fbits = 8'h00;
   logic [7:0] blen = 8'h14;
   int err_total = 0;
   int checks_done = 0;

   // ==========================================================
   // Clock, wiring and instances
   // ==========================================================
   always #25 sys_clk = ~sys_clk;
   assign dq_bus = pins.dq_oe ? pins.dq : mdl_dq;
   fsc_ctrl u_fsc_ctrl (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack), .irq(irq), .flash_o(pins), .dq_i(dq_bus),
      .ready_busy_i(ready_busy), .supply_high_i(supply_hi));
   fsc_flash_model u_fsc_flash_model (.sys_clk(sys_clk), .pins(pins),
      .fail_bits(fbits), .busy_len(blen), .dq(mdl_dq),
      .ready_busy(ready_busy));

   // ==========================================================
   // Bus and check helpers
   // ==========================================================
   // One classic cycle; the request holds until ack is sampled high.
   task automatic wb_xfer(input logic w, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_dat <= d;
      wb_sel <= 4'hF;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 100);
      q = wb_dat_o;
      if (n >= 100) begin
         err_total++;
         $display("[ERR] bus ack expected 1 seen %b", wb_ack);
      end
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a,
                         input logic [31:0] e, input logic [31:0] m);
      logic [31:0] q;
      wb_xfer(1'b0, a, 32'h0, q);
      chk(nm, e, q & m);
   endtask

   // Starts an operation and polls the busy bit, giving up after 300 reads.
   task automatic run_op(input logic [3:0] op, input logic [7:0] fb);
      logic [31:0] q;
      int n;
      n = 0;
      fbits <= fb;
      wb_xfer(1'b1, fsc_pkg::REG_CMD, {28'h0, op}, q);
      do begin
         wb_xfer(1'b0, fsc_pkg::REG_STATUS, 32'h0, q);
         n++;
      end while (q[8] !== 1'b0 && n < 300);
      chk("busy", 32'h0, {31'h0, q[8]});
   endtask

   task automatic irq_clr();
      logic [31:0] q;
      wb_xfer(1'b1, fsc_pkg::REG_IRQ_CLR, 32'h7F, q);
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_reset();
      rd_chk("irq_en", fsc_pkg::REG_IRQ_EN, 32'h0, 32'h7F);
      rd_chk("status", fsc_pkg::REG_STATUS, 32'h0, 32'h1FF);
      rd_chk("irq_stat", fsc_pkg::REG_IRQ_STAT, 32'h0, 32'h7F);
      rd_chk("unmapped", 8'h20, 32'h0, 32'hFFFFFFFF);
      rd_chk("ready_pin", fsc_pkg::REG_STATUS, 32'h600, 32'h600);
      chk("irq", 32'h0, {31'h0, irq});
      chk("rp_n", 32'h1, {31'h0, pins.rp_n});
   endtask

   // Completion is masked, then enabled, then cleared.
   task automatic t_irq_done();
      logic [31:0] q;
      run_op(4'h2, 8'h00);
      rd_chk("status", fsc_pkg::REG_STATUS, 32'h80,
             32'hFF);
      chk("irq masked", 32'h0, {31'h0, irq});
      wb_xfer(1'b1, fsc_pkg::REG_IRQ_EN, 32'h7F, q);
      chk("irq", 32'h1, {31'h0, irq});
      rd_chk("irq_stat", fsc_pkg::REG_IRQ_STAT, 32'h1, 32'h7F);
      irq_clr();
      chk("irq cleared", 32'h0, {31'h0, irq});
   endtask

   // Each error flag, from clear status, with a short busy time.
   task automatic t_errors();
      logic [3:0] ops [5] = '{4'h2, 4'h1, 4'h3, 4'h5, 4'h4};
      logic [7:0] fb [5] = '{8'h20, 8'h10, 8'h30, 8'h28, 8'h12};
      logic [7:0] ex [5] = '{8'h03, 8'h05, 8'h0F, 8'h13, 8'h25};
      blen <= 8'h02;
      for (int i = 0; i < 5; i++) begin
         run_op(4'h8, 8'h00);
         irq_clr();
         run_op(ops[i], fb[i]);
         rd_chk("err status", fsc_pkg::REG_STATUS, {24'h0, fb[i] | 8'h80},
                32'hFF);
         rd_chk("err irq", fsc_pkg::REG_IRQ_STAT, {24'h0, ex[i]},
                32'h7F);
      end
      blen <= 8'h14;
   endtask

   // Flags persist over a good operation; low supply is not trusted.
   task automatic t_sticky();
      run_op(4'h1, 8'h00);
      rd_chk("sticky", fsc_pkg::REG_STATUS, 32'h92,
             32'hFF);
      run_op(4'h8, 8'h00);
      run_op(4'h9, 8'h00);
      rd_chk("cleared", fsc_pkg::REG_STATUS, 32'h80, 32'hFF);
      supply_hi <= 1'b0;
      irq_clr();
      run_op(4'h1, 8'h08);
      rd_chk("supply off", fsc_pkg::REG_IRQ_STAT, 32'h1, 32'h7F);
      rd_chk("supply pin", fsc_pkg::REG_STATUS, 32'h0, 32'h400);
      supply_hi <= 1'b1;
      run_op(4'h8, 8'h00);
   endtask

   // Suspend after erase and after write, then resume.
   task automatic t_suspend();
      run_op(4'h2, 8'h00);
      irq_clr();
      run_op(4'h6, 8'h00);
      rd_chk("erase pause", fsc_pkg::REG_STATUS, 32'hC0, 32'hFF);
      rd_chk("pause irq", fsc_pkg::REG_IRQ_STAT, 32'h41, 32'h7F);
      run_op(4'h7, 8'h00);
      rd_chk("resumed", fsc_pkg::REG_STATUS, 32'h80, 32'hFF);
      run_op(4'h1, 8'h00);
      run_op(4'h6, 8'h00);
      rd_chk("write pause", fsc_pkg::REG_STATUS, 32'h84, 32'hFF);
      run_op(4'h7, 8'h00);
      rd_chk("resumed", fsc_pkg::REG_STATUS, 32'h80, 32'hFF);
   endtask

   // Array byte and identifier code come back through the data register.
   task automatic t_reads();
      logic [31:0] q;
      wb_xfer(1'b1, fsc_pkg::REG_ADDR, 32'h123, q);
      wb_xfer(1'b1, fsc_pkg::REG_WDATA, 32'h5C, q);
      rd_chk("addr", fsc_pkg::REG_ADDR, 32'h123, 32'hFFFFFFFF);
      rd_chk("wdata", fsc_pkg::REG_WDATA, 32'h5C, 32'hFFFFFFFF);
      run_op(4'h0, 8'h00);
      rd_chk("array", fsc_pkg::REG_RDATA, 32'h79, 32'hFF);
      run_op(4'hA, 8'h00);
      rd_chk("ident", fsc_pkg::REG_RDATA, 32'hA5, 32'hFF);
      rd_chk("last op", fsc_pkg::REG_CMD, 32'hA, 32'hFFFFFFFF);
   endtask

   task automatic results();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence and watchdog
   // ==========================================================
   initial begin
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_irq_done();
      t_errors();
      t_sticky();
      t_suspend();
      t_reads();
      results();
   end

   // The whole run needs well under this many clocks.
   initial begin
      repeat (80000) @(posedge sys_clk);
      err_total++;
      results();
   end
endmodule
